// ==== pscr_pkg.sv ====
// Shared constants and carrier types for the port switch control register bank
package pscr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int RATE_W = 7;
    localparam int NUM_QUEUES = 4;
    localparam int CNT_NUM = 30;
    localparam int CNT_W = 36;
    localparam int CNT_LO_W = 32;
    localparam int CNT_HI_W = 4;
    localparam int IDX_W = 8;
    localparam int ADDR_W = 12;
    localparam int FRI_W = 4;

    // ------------------------------------------------------------
    // Byte offsets inside the port region
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_EGR_Q0 = 12'h420;
    localparam logic [11:0] OFF_EGR_Q1 = 12'h421;
    localparam logic [11:0] OFF_EGR_Q2 = 12'h422;
    localparam logic [11:0] OFF_EGR_Q3 = 12'h423;
    localparam logic [11:0] OFF_CSR_B3 = 12'h500;
    localparam logic [11:0] OFF_CSR_B2 = 12'h501;
    localparam logic [11:0] OFF_CSR_B1 = 12'h502;
    localparam logic [11:0] OFF_CSR_B0 = 12'h503;
    localparam logic [11:0] OFF_DAT_B3 = 12'h504;
    localparam logic [11:0] OFF_DAT_B2 = 12'h505;
    localparam logic [11:0] OFF_DAT_B1 = 12'h506;
    localparam logic [11:0] OFF_DAT_B0 = 12'h507;
    localparam logic [11:0] OFF_ACL_B0 = 12'h600;
    localparam logic [11:0] OFF_ACL_B1 = 12'h601;
    localparam logic [11:0] OFF_ACL_B2 = 12'h602;
    localparam logic [11:0] OFF_ACL_B3 = 12'h603;

    // ------------------------------------------------------------
    // Field positions within the byte they live in
    // ------------------------------------------------------------
    localparam int CSR_OVF_BIT = 7;     // bit 31 of the word
    localparam int CSR_START_BIT = 1;   // bit 25 of the word
    localparam int CSR_EN_BIT = 0;      // bit 24 of the word
    localparam int ACL_MODE_LSB = 4;
    localparam int ACL_ENA_LSB = 2;
    localparam int ACL_SRC_BIT = 1;
    localparam int ACL_EQ_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and mode codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] ACL_MODE_NONE = 2'b00;
    localparam logic [1:0] ACL_MODE_L2 = 2'b01;
    localparam logic [1:0] ACL_MODE_L3 = 2'b10;
    localparam logic [1:0] ACL_MODE_L4 = 2'b11;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic port_wide;
        logic [NUM_QUEUES-1:0][RATE_W-1:0] rate;
    } pscr_rate_t;

    typedef struct packed {
        logic [FRI_W-1:0] first_rule_index;
        logic [1:0] mode;
        logic [1:0] enable;
        logic src_sel;
        logic cmp_equal;
        logic [15:0] mac_hi;
    } pscr_acl_t;

    typedef struct packed {
        logic ovf;
        logic [CNT_W-1:0] value;
    } pscr_cnt_rd_t;

endpackage

// ==== pscr_egress_rates.sv ====
// Egress rate staging: pending per-queue codes committed as a group
`timescale 1ns/1ps
`default_nettype none
module pscr_egress_rates #(
    parameter int RATE_W = pscr_pkg::RATE_W,
    parameter int NQ = pscr_pkg::NUM_QUEUES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Register writes
    input wire logic [NQ-1:0] i_wr,
    input wire logic [RATE_W-1:0] i_wdata,
    // Global mode
    input wire logic i_port_wide,
    // Results
    output logic [NQ-1:0][RATE_W-1:0] o_pending,
    output pscr_pkg::pscr_rate_t o_rates
);

    logic [NQ-1:0][RATE_W-1:0] active_q;

    // Software-visible values; they alone do not steer the shaper
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pending <= '0;
        end else begin
            for (int q = 0; q < NQ; q++) begin
                if (i_wr[q]) begin
                    o_pending[q] <= i_wdata;
                end
            end
        end
    end

    // Writing the last queue commits all four at once
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            active_q <= '0;
        end else if (i_wr[NQ-1]) begin
            active_q <= {i_wdata, o_pending[NQ-2:0]};
        end
    end

    // Port-wide mode uses only queue zero, so o_rates drives the others as zero; register reads still return the pending codes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rates <= '0;
        end else begin
            o_rates.port_wide <= i_port_wide;
            o_rates.rate[0] <= active_q[0];
            for (int q = 1; q < NQ; q++) begin
                o_rates.rate[q] <= i_port_wide ? '0 : active_q[q];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pending_held;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr[0] && !i_wr[NQ-1]) |=> (active_q[0] == $past(active_q[0]));
    endproperty
    a_pending_held: assert property (p_pending_held) else $error("queue0 took effect early");

    property p_commit;
        @(posedge i_clk) disable iff (!i_resetn)
        i_wr[NQ-1] |=> (active_q[0] == $past(o_pending[0])) ##1
            (o_rates.rate[0] == $past(active_q[0]));
    endproperty
    a_commit: assert property (p_commit) else $error("commit did not reach output");

    property p_port_wide_mask;
        @(posedge i_clk) disable iff (!i_resetn)
        i_port_wide |=> (o_rates.rate[1] == '0) && (o_rates.rate[2] == '0)
            && (o_rates.rate[3] == '0);
    endproperty
    a_port_wide_mask: assert property (p_port_wide_mask) else $error("queue rate used in port mode");

endmodule
`default_nettype wire

// ==== pscr_counter_bank.sv ====
// Statistics counter storage with read-clear and flush/freeze gating
`timescale 1ns/1ps
`default_nettype none
module pscr_counter_bank #(
    parameter int NUM = pscr_pkg::CNT_NUM,
    parameter int W = pscr_pkg::CNT_W,
    parameter int IW = pscr_pkg::IDX_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Count events and global control
    input wire logic [NUM-1:0] i_events,
    input wire logic i_flush,
    input wire logic i_freeze,
    input wire logic i_port_en,
    // Read request and answer
    input wire logic i_rd_start,
    input wire logic [IW-1:0] i_rd_idx,
    output logic o_rd_done,
    output pscr_pkg::pscr_cnt_rd_t o_rd
);

    logic [NUM-1:0][W-1:0] cnt_q;
    logic [NUM-1:0] ovf_q;
    logic frozen;
    logic flushing;

    // Index beyond the last counter reads as zero
    function automatic logic idx_hit(input logic [IW-1:0] idx, input int n);
        idx_hit = (int'(idx) == n);
    endfunction

    assign frozen = i_freeze && i_port_en;
    assign flushing = i_flush && i_port_en;

    // Counters; a read clears but keeps an event that lands in the same cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
            ovf_q <= '0;
        end else begin
            for (int i = 0; i < NUM; i++) begin
                if (flushing) begin
                    cnt_q[i] <= '0;
                    ovf_q[i] <= 1'b0;
                end else if (i_rd_start && idx_hit(i_rd_idx, i)) begin
                    cnt_q[i] <= W'(i_events[i] && !frozen);
                    ovf_q[i] <= 1'b0;
                end else if (i_events[i] && !frozen) begin
                    cnt_q[i] <= cnt_q[i] + W'(1);
                    ovf_q[i] <= ovf_q[i] | (&cnt_q[i]);
                end
            end
        end
    end

    // Answer one cycle after the request
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_done <= 1'b0;
            o_rd <= '0;
        end else begin
            o_rd_done <= i_rd_start;
            if (i_rd_start) begin
                o_rd <= '0;
                for (int i = 0; i < NUM; i++) begin
                    if (idx_hit(i_rd_idx, i)) begin
                        o_rd <= {ovf_q[i], cnt_q[i]};
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_read_clears;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd_start && i_rd_idx == '0 && !i_events[0] && !flushing) |=> (cnt_q[0] == '0);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("counter not cleared by read");

    property p_flush;
        @(posedge i_clk) disable iff (!i_resetn)
        flushing |=> (cnt_q == '0) && (ovf_q == '0);
    endproperty
    a_flush: assert property (p_flush) else $error("enabled flush left counts");

    property p_freeze;
        @(posedge i_clk) disable iff (!i_resetn)
        (frozen && !flushing && !i_rd_start) |=> $stable(cnt_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen counter moved");

endmodule
`default_nettype wire

// ==== pscr_port_regs.sv ====
// Per-port switch control register bank: egress rates, counter access, ACL staging
`timescale 1ns/1ps
`default_nettype none
module pscr_port_regs #(
    parameter int NUM_CNT = pscr_pkg::CNT_NUM
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Byte-wide management access
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [pscr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Global switch control
    input wire logic i_port_wide_mode,
    input wire logic i_cnt_flush,
    input wire logic i_cnt_freeze,
    input wire logic [NUM_CNT-1:0] i_cnt_events,
    // ACL probe values from the frame parser
    input wire logic [15:0] i_probe_src,
    input wire logic [15:0] i_probe_dst,
    // Configuration towards the datapath
    output pscr_pkg::pscr_rate_t o_rates,
    output pscr_pkg::pscr_acl_t o_acl,
    output logic o_acl_match
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [pscr_pkg::NUM_QUEUES-1:0] wr_rate;
    logic [pscr_pkg::NUM_QUEUES-1:0][pscr_pkg::RATE_W-1:0] rate_pending;
    logic wr_csr3;
    logic wr_csr2;
    logic rd_start;

    // Address compare used by every strobe
    function automatic logic hit(input logic [pscr_pkg::ADDR_W-1:0] a,
                                 input logic [pscr_pkg::ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Write strobes
    assign wr_rate[0] = i_wr_en && hit(i_addr, pscr_pkg::OFF_EGR_Q0);
    assign wr_rate[1] = i_wr_en && hit(i_addr, pscr_pkg::OFF_EGR_Q1);
    assign wr_rate[2] = i_wr_en && hit(i_addr, pscr_pkg::OFF_EGR_Q2);
    assign wr_rate[3] = i_wr_en && hit(i_addr, pscr_pkg::OFF_EGR_Q3);
    assign wr_csr3 = i_wr_en && hit(i_addr, pscr_pkg::OFF_CSR_B3);
    assign wr_csr2 = i_wr_en && hit(i_addr, pscr_pkg::OFF_CSR_B2);

    // ------------------------------------------------------------
    // Egress rates
    // ------------------------------------------------------------
    pscr_egress_rates #(
        .RATE_W(pscr_pkg::RATE_W),
        .NQ(pscr_pkg::NUM_QUEUES)
    ) u_rates (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_wr(wr_rate),
        .i_wdata(i_wdata[pscr_pkg::RATE_W-1:0]),
        .i_port_wide(i_port_wide_mode),
        .o_pending(rate_pending),
        .o_rates(o_rates)
    );

    // ------------------------------------------------------------
    // Counter access
    // ------------------------------------------------------------
    logic start_q;
    logic port_en_q;
    logic [pscr_pkg::IDX_W-1:0] idx_q;
    logic [pscr_pkg::IDX_W-1:0] rd_idx;
    logic ovf_q;
    logic [pscr_pkg::CNT_HI_W-1:0] cnt_hi_q;
    logic [pscr_pkg::CNT_LO_W-1:0] cnt_lo_q;
    logic rd_done;
    pscr_pkg::pscr_cnt_rd_t rd_val;

    // A start while a read is in flight is dropped; the first index stands
    assign rd_start = wr_csr3 && i_wdata[pscr_pkg::CSR_START_BIT] && !start_q;
    // An index written with the start byte in the same access is not possible
    assign rd_idx = idx_q;

    // Busy flag: set by software, cleared by hardware when the count lands
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_q <= 1'b0;
        end else if (rd_start) begin
            start_q <= 1'b1;
        end else if (rd_done) begin
            start_q <= 1'b0;
        end
    end

    // Port enable and counter index
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            port_en_q <= 1'b0;
            idx_q <= '0;
        end else begin
            if (wr_csr3) begin
                port_en_q <= i_wdata[pscr_pkg::CSR_EN_BIT];
            end
            if (wr_csr2) begin
                idx_q <= i_wdata;
            end
        end
    end

    pscr_counter_bank #(
        .NUM(NUM_CNT),
        .W(pscr_pkg::CNT_W),
        .IW(pscr_pkg::IDX_W)
    ) u_counters (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_events(i_cnt_events),
        .i_flush(i_cnt_flush),
        .i_freeze(i_cnt_freeze),
        .i_port_en(port_en_q),
        .i_rd_start(rd_start),
        .i_rd_idx(rd_idx),
        .o_rd_done(rd_done),
        .o_rd(rd_val)
    );

    // Result is split across the two words; data only changes on completion
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ovf_q <= 1'b0;
            cnt_hi_q <= '0;
            cnt_lo_q <= '0;
        end else if (rd_done) begin
            ovf_q <= rd_val.ovf;
            cnt_hi_q <= rd_val.value[pscr_pkg::CNT_W-1:pscr_pkg::CNT_LO_W];
            cnt_lo_q <= rd_val.value[pscr_pkg::CNT_LO_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // ACL staging
    // ------------------------------------------------------------
    // Table storage sits elsewhere; these bytes are its only window
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_acl <= '0;
        end else if (i_wr_en) begin
            if (hit(i_addr, pscr_pkg::OFF_ACL_B0)) begin
                o_acl.first_rule_index <= i_wdata[pscr_pkg::FRI_W-1:0];
            end else if (hit(i_addr, pscr_pkg::OFF_ACL_B1)) begin
                o_acl.mode <= i_wdata[pscr_pkg::ACL_MODE_LSB +: 2];
                o_acl.enable <= i_wdata[pscr_pkg::ACL_ENA_LSB +: 2];
                o_acl.src_sel <= i_wdata[pscr_pkg::ACL_SRC_BIT];
                o_acl.cmp_equal <= i_wdata[pscr_pkg::ACL_EQ_BIT];
            end else if (hit(i_addr, pscr_pkg::OFF_ACL_B2)) begin
                o_acl.mac_hi[15:8] <= i_wdata;
            end else if (hit(i_addr, pscr_pkg::OFF_ACL_B3)) begin
                o_acl.mac_hi[7:0] <= i_wdata;
            end
        end
    end

    // Reserved bits 7:6 of byte one are writable storage
    logic [1:0] acl_b1_rsvd_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acl_b1_rsvd_q <= '0;
        end else if (i_wr_en && hit(i_addr, pscr_pkg::OFF_ACL_B1)) begin
            acl_b1_rsvd_q <= i_wdata[7:6];
        end
    end

    // Layer-2 match on the staged MAC high bytes; other modes never match here
    logic [15:0] probe_sel;
    assign probe_sel = o_acl.src_sel ? i_probe_src : i_probe_dst;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_acl_match <= 1'b0;
        end else if (o_acl.mode == pscr_pkg::ACL_MODE_L2) begin
            o_acl_match <= o_acl.cmp_equal ? (probe_sel == o_acl.mac_hi)
                                           : (probe_sel != o_acl.mac_hi);
        end else begin
            o_acl_match <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = pscr_pkg::RST_BYTE;
        if (hit(i_addr, pscr_pkg::OFF_EGR_Q0)) begin
            rd_mux = {1'b0, rate_pending[0]};
        end else if (hit(i_addr, pscr_pkg::OFF_EGR_Q1)) begin
            rd_mux = {1'b0, rate_pending[1]};
        end else if (hit(i_addr, pscr_pkg::OFF_EGR_Q2)) begin
            rd_mux = {1'b0, rate_pending[2]};
        end else if (hit(i_addr, pscr_pkg::OFF_EGR_Q3)) begin
            rd_mux = {1'b0, rate_pending[3]};
        end else if (hit(i_addr, pscr_pkg::OFF_CSR_B3)) begin
            rd_mux = {ovf_q, 5'h00, start_q, port_en_q};
        end else if (hit(i_addr, pscr_pkg::OFF_CSR_B2)) begin
            rd_mux = idx_q;
        end else if (hit(i_addr, pscr_pkg::OFF_CSR_B0)) begin
            rd_mux = {4'h0, cnt_hi_q};
        end else if (hit(i_addr, pscr_pkg::OFF_DAT_B3)) begin
            rd_mux = cnt_lo_q[31:24];
        end else if (hit(i_addr, pscr_pkg::OFF_DAT_B2)) begin
            rd_mux = cnt_lo_q[23:16];
        end else if (hit(i_addr, pscr_pkg::OFF_DAT_B1)) begin
            rd_mux = cnt_lo_q[15:8];
        end else if (hit(i_addr, pscr_pkg::OFF_DAT_B0)) begin
            rd_mux = cnt_lo_q[7:0];
        end else if (hit(i_addr, pscr_pkg::OFF_ACL_B0)) begin
            rd_mux = {4'h0, o_acl.first_rule_index};
        end else if (hit(i_addr, pscr_pkg::OFF_ACL_B1)) begin
            rd_mux = {acl_b1_rsvd_q, o_acl.mode, o_acl.enable, o_acl.src_sel,
                      o_acl.cmp_equal};
        end else if (hit(i_addr, pscr_pkg::OFF_ACL_B2)) begin
            rd_mux = o_acl.mac_hi[15:8];
        end else if (hit(i_addr, pscr_pkg::OFF_ACL_B3)) begin
            rd_mux = o_acl.mac_hi[7:0];
        end
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= pscr_pkg::RST_BYTE;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            o_rdata <= i_rd_en ? rd_mux : pscr_pkg::RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_start;
        rd_start;
    endsequence

    // Busy for exactly the one cycle in which the count is fetched
    sequence s_done_clear;
        start_q ##1 !start_q;
    endsequence

    property p_start_self_clear;
        @(posedge i_clk) disable iff (!i_resetn)
        s_start |=> s_done_clear;
    endproperty
    a_start_self_clear: assert property (p_start_self_clear) else $error("read bit stuck");

    property p_rate_msb_zero;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd_en && hit(i_addr, pscr_pkg::OFF_EGR_Q0)) |=> !o_rdata[7] && o_rvalid;
    endproperty
    a_rate_msb_zero: assert property (p_rate_msb_zero) else $error("rate top bit set");

    property p_fri_upper_zero;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd_en && hit(i_addr, pscr_pkg::OFF_ACL_B0)) |=> (o_rdata[7:4] == 4'h0);
    endproperty
    a_fri_upper_zero: assert property (p_fri_upper_zero) else $error("rule index top bits set");

    property p_split;
        @(posedge i_clk) disable iff (!i_resetn)
        rd_done |=> (cnt_hi_q == $past(rd_val.value[pscr_pkg::CNT_W-1:pscr_pkg::CNT_LO_W]))
                    && (cnt_lo_q == $past(rd_val.value[pscr_pkg::CNT_LO_W-1:0]));
    endproperty
    a_split: assert property (p_split) else $error("count split wrong");

    property p_mode_gate;
        @(posedge i_clk) disable iff (!i_resetn)
        (o_acl.mode != pscr_pkg::ACL_MODE_L2) |=> !o_acl_match;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("match outside MAC mode");

endmodule
`default_nettype wire

// ==== pscr_tb.sv ====
// Self-checking bench for the port switch control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // Stimulus, model and bookkeeping
    // ----------------------------------------
    logic clk = 0, rstn = 0, wr = 0, rd = 0, pw = 0, fl = 0, fz = 0, rv, am;
    logic [11:0] ad = 0;
    logic [7:0] wd = 0, rdat, b, got;
    logic [29:0] ev = 0;
    logic [15:0] ps = 0, pd = 0, mac;
    logic [31:0] seed = 32'h21b3;
    logic [11:0] offs [9] = '{12'h420, 12'h423, 12'h500, 12'h501, 12'h503,
        12'h504, 12'h507, 12'h600, 12'h7ff};
    pscr_pkg::pscr_rate_t rates;
    pscr_pkg::pscr_acl_t acl;
    int mismatches = 0, compares = 0, cyc = 0, act [4] = '{0, 0, 0, 0}, pend [4];
    // Clock, 40 ns period
    initial forever #20 clk = ~clk;
    pscr_port_regs u_dut (.i_clk(clk), .i_resetn(rstn), .i_wr_en(wr), .i_rd_en(rd),
        .i_addr(ad), .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .i_port_wide_mode(pw),
        .i_cnt_flush(fl), .i_cnt_freeze(fz), .i_cnt_events(ev), .i_probe_src(ps),
        .i_probe_dst(pd), .o_rates(rates), .o_acl(acl), .o_acl_match(am));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Strobe held for exactly one sampling edge
    task automatic wbyte(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ad <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rbyte(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        ad <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rv, 1);
        d = rdat;
    endtask
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            ev <= 30'(1) << k;
            @(posedge clk);
            ev <= '0;
        end
    endtask
    // Start bit stays set while busy, so poll it under a bound
    task automatic read_cnt(input logic [7:0] idx, input logic en, input int exp);
        wbyte(12'h501, idx);
        wbyte(12'h500, {6'h0, 1'b1, en});
        got = 8'h02;
        for (int t = 0; t < 20 && got[1] === 1'b1; t++) rbyte(12'h500, got);
        check(got, {7'h0, en});
        rbyte(12'h503, got);
        check(got, 0);
        rbyte(12'h507, got);
        check(got, exp);
        rbyte(12'h501, got);
        check(got, idx);
    endtask
    task automatic chk_rates();
        repeat (3) @(posedge clk);
        #1;
        check(rates, {pw, 7'(pw ? 0 : act[3]), 7'(pw ? 0 : act[2]), 7'(pw ? 0 : act[1]), 7'(act[0])});
    endtask
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (offs[i]) begin
            rbyte(offs[i], got);
            check(got, 0);
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            pw <= k[0];
            for (int q = 0; q < 4; q++) begin
                b = 8'(rnd());
                wbyte(12'(12'h420 + q), b);
                pend[q] = b[6:0];
                rbyte(12'(12'h420 + q), got);
                check(got, pend[q]);
                if (q == 2) chk_rates();
            end
            act = pend;
            chk_rates();
        end
        wbyte(12'h600, 8'hff);
        rbyte(12'h600, got);
        check(got, 8'h0f);
        for (int k = 0; k < 8; k++) begin
            b = 8'(rnd());
            b[5:4] = k[1:0];
            mac = 16'(rnd());
            wbyte(12'h601, b);
            wbyte(12'h602, mac[15:8]);
            wbyte(12'h603, mac[7:0]);
            @(posedge clk);
            ps <= k[2] ? mac : 16'(rnd());
            pd <= k[2] ? 16'(rnd()) : mac;
            repeat (3) @(posedge clk);
            #1;
            check(acl, {4'hf, b[5:0], mac});
            check(am, b[5:4] == 2'b01 && b[0] == ((b[1] ? ps : pd) == mac));
            rbyte(12'h601, got);
            check(got, b);
        end
        // Pass 0 reads counter zero, pass 3 freezes the last two events
        for (int k = 0; k < 4; k++) begin
            b = k == 0 ? 8'h00 : 8'(rnd() % 30);
            wbyte(12'h500, {7'h0, k != 2});
            pulse(b, 5);
            @(posedge clk);
            fl <= k == 1 || k == 2;
            @(posedge clk);
            fl <= 1'b0;
            fz <= k == 3;
            pulse(b, 2);
            fz <= 1'b0;
            read_cnt(b, k != 2, k == 1 ? 2 : (k == 3 ? 5 : 7));
            read_cnt(b, k != 2, 0);
        end
        summarize();
    end
endmodule
`default_nettype wire
